// ===== hw/jtt_sync.sv
`timescale 1ns/1ns
// ==================================================================
// two flip-flop synchroniser, async clear
module jtt_sync
  import jtt_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // first stage feeds only the second
  always_comb begin
    nxt_meta = d;
    nxt_q = meta_ff;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= {W{SYNC_RST_VAL}};
      q_ff <= {W{SYNC_RST_VAL}};
    end else begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule : jtt_sync

// ===== hw/jtt_tap.sv
`timescale 1ns/1ns
module jtt_tap
  import jtt_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h10000001 // arbitrary value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe,
  input wire logic core_tdo,
  output logic core_sel,
  input wire logic alt_function_select_bit,
  output logic test_pins_active,
  input wire logic [BDY_W-1:0] bdy_in,
  output logic [BDY_W-1:0] bdy_out,
  output logic bdy_drive,
  output logic [BDY_W-1:0] upd_word,
  output logic upd_pulse
);

  // ================================================================
  // functions
  function automatic logic [3:0] decode(input logic [3:0] ir);
    logic [3:0] r;
    r = IR_BYPASS;
    unique case (ir)
      IR_EXTEST, IR_INTEST, IR_SAMPLE, IR_ABORT, IR_DPACC, IR_APACC,
      IR_IDCODE, IR_BYPASS: r = ir;
      default: r = IR_BYPASS;
    endcase
    return r;
  endfunction : decode

  function automatic logic [5:0] chain_len(input logic [3:0] ins);
    logic [5:0] r;
    r = LEN_NONE;
    unique case (ins)
      IR_IDCODE: r = LEN_IDCODE;
      IR_SAMPLE: r = LEN_BDY;
      IR_BYPASS: r = LEN_BYPASS;
      default: r = LEN_NONE; // extest, intest, core chains
    endcase
    return r;
  endfunction : chain_len

  function automatic logic is_core(input logic [3:0] ins);
    return (ins == IR_ABORT) || (ins == IR_DPACC) || (ins == IR_APACC);
  endfunction : is_core

  // shift right, new bit enters at the chain's top position
  function automatic logic [31:0] shift_in(input logic [31:0] sh,
                                           input logic [5:0] len,
                                           input logic d);
    logic [31:0] r;
    r = sh >> 1;
    r[5'(len - 6'h01)] = d;
    return r;
  endfunction : shift_in

  // ================================================================
  // resets and crossings
  logic rst_sync_n;
  logic tap_arst_n;
  logic tap_rst_n;
  logic [BDY_W-1:0] bdy_pin_s;
  logic tgl_s;
  logic upd_tgl_ff;

  // system reset release through two flops
  jtt_sync #(.W(1)) u_rst_sync (
    .clk(clk),
    .arst_n(rstn),
    .d(1'b1),
    .q(rst_sync_n)
  );

  // test reset or power-on reset, asserted at once
  assign tap_arst_n = trst_n & rst_sync_n;

  jtt_sync #(.W(1)) u_tap_rst_sync (
    .clk(tck),
    .arst_n(tap_arst_n),
    .d(1'b1),
    .q(tap_rst_n)
  );

  // boundary pin levels into the test clock domain
  jtt_sync #(.W(BDY_W)) u_bdy_sync (
    .clk(tck),
    .arst_n(tap_rst_n),
    .d(bdy_in),
    .q(bdy_pin_s)
  );

  // update event toggle into the system domain
  jtt_sync #(.W(1)) u_tgl_sync (
    .clk(clk),
    .arst_n(rst_sync_n),
    .d(upd_tgl_ff),
    .q(tgl_s)
  );

  // ================================================================
  // controller state machine (test clock domain)
  jtt_state_type state_ff, nxt_state;

  // standard transitions, only on rising tck
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_TLR: nxt_state = tms ? ST_TLR : ST_RTI;
      ST_RTI: nxt_state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: nxt_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_state = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_state = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_state = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: nxt_state = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_state = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_state = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_state = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_state = tms ? ST_SEL_DR : ST_RTI;
      default: nxt_state = ST_TLR;
    endcase
  end

  // changes on rising tck only, or at once to ST_TLR on reset
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_ff <= ST_TLR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ================================================================
  // instruction and data chains
  logic [3:0] ir_ff, nxt_ir;
  logic [3:0] ir_sh_ff, nxt_ir_sh;
  logic [31:0] dr_sh_ff, nxt_dr_sh;
  logic [BDY_W-1:0] bdy_upd_ff, nxt_bdy_upd;
  logic nxt_upd_tgl;
  logic bdy_drive_ff, nxt_bdy_drive;
  logic [3:0] act;
  logic [5:0] len;

  assign act = decode(ir_ff);
  assign len = chain_len(act);

  // capture, shift and update as the state says
  always_comb begin
    nxt_ir = ir_ff;
    nxt_ir_sh = ir_sh_ff;
    nxt_dr_sh = dr_sh_ff;
    nxt_bdy_upd = bdy_upd_ff;
    nxt_upd_tgl = upd_tgl_ff;
    nxt_bdy_drive = (act == IR_EXTEST);
    unique case (state_ff)
      ST_CAP_IR: nxt_ir_sh = IR_CAPT_VAL;
      ST_SH_IR: nxt_ir_sh = {tdi, ir_sh_ff[3:1]};
      ST_UPD_IR: nxt_ir = ir_sh_ff;
      ST_CAP_DR: begin
        unique case (act)
          IR_IDCODE: nxt_dr_sh = ID_VALUE;
          IR_SAMPLE: nxt_dr_sh = {24'h000000, bdy_pin_s};
          IR_BYPASS: nxt_dr_sh = {31'h00000000, BYPASS_CAPT_VAL};
          default: nxt_dr_sh = dr_sh_ff;
        endcase
      end
      ST_SH_DR: begin
        if (len != LEN_NONE) begin
          nxt_dr_sh = shift_in(dr_sh_ff, len, tdi);
        end
      end
      ST_UPD_DR: begin
        if (act == IR_SAMPLE) begin
          nxt_bdy_upd = dr_sh_ff[BDY_W-1:0];
          nxt_upd_tgl = ~upd_tgl_ff;
        end
      end
      default: nxt_ir = ir_ff;
    endcase
    if (nxt_state == ST_TLR) begin
      nxt_ir = IR_IDCODE;
    end
  end

  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_ff <= IR_RST_VAL;
      ir_sh_ff <= IR_CAPT_VAL;
      dr_sh_ff <= DR_RST_VAL;
      bdy_upd_ff <= BDY_RST_VAL;
      bdy_drive_ff <= 1'b0;
    end else begin
      ir_ff <= nxt_ir;
      ir_sh_ff <= nxt_ir_sh;
      dr_sh_ff <= nxt_dr_sh;
      bdy_upd_ff <= nxt_bdy_upd;
      bdy_drive_ff <= nxt_bdy_drive;
    end
  end

  // update toggle, cleared only by power-on reset so a test reset
  // never looks like an update on the system side; the state is held
  // in reset past this release, so the flop holds its value then
  always_ff @(posedge tck or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      upd_tgl_ff <= 1'b0;
    end else begin
      upd_tgl_ff <= nxt_upd_tgl;
    end
  end

  assign bdy_out = bdy_upd_ff;
  assign bdy_drive = bdy_drive_ff;
  assign core_sel = is_core(act);

  // ================================================================
  // serial output, falling tck edge
  logic tdo_ff, nxt_tdo;
  logic tdo_oe_ff, nxt_tdo_oe;

  // drive only in shift states with a live chain
  always_comb begin
    nxt_tdo = 1'b0;
    nxt_tdo_oe = 1'b0;
    if (state_ff == ST_SH_IR) begin
      nxt_tdo = ir_sh_ff[0];
      nxt_tdo_oe = 1'b1;
    end else if (state_ff == ST_SH_DR) begin
      if (is_core(act)) begin
        nxt_tdo = core_tdo;
        nxt_tdo_oe = 1'b1;
      end else if (len != LEN_NONE) begin
        nxt_tdo = dr_sh_ff[0];
        nxt_tdo_oe = 1'b1;
      end
    end
  end

  always_ff @(negedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign tdo_o = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // ================================================================
  // system clock side: update hand-off and pin function
  logic tgl_seen_ff, nxt_tgl_seen;
  logic [BDY_W-1:0] upd_word_ff, nxt_upd_word;
  logic upd_pulse_ff, nxt_upd_pulse;
  logic pins_ff, nxt_pins;

  // word is held stable in the test domain past the toggle
  always_comb begin
    nxt_tgl_seen = tgl_s;
    nxt_upd_pulse = (tgl_s != tgl_seen_ff);
    nxt_upd_word = nxt_upd_pulse ? bdy_upd_ff : upd_word_ff;
    nxt_pins = alt_function_select_bit;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tgl_seen_ff <= 1'b0;
      upd_pulse_ff <= 1'b0;
      upd_word_ff <= BDY_RST_VAL;
      pins_ff <= ALT_RST_VAL;
    end else begin
      tgl_seen_ff <= nxt_tgl_seen;
      upd_pulse_ff <= nxt_upd_pulse;
      upd_word_ff <= nxt_upd_word;
      pins_ff <= nxt_pins;
    end
  end

  assign upd_word = upd_word_ff;
  assign upd_pulse = upd_pulse_ff;
  assign test_pins_active = pins_ff;

  // ================================================================
  // assertions
  property p_five_tms;
    @(posedge tck) disable iff (!tap_rst_n)
    tms [*5] |=> state_ff == ST_TLR;
  endproperty
  a_five_tms: assert property (p_five_tms)
    else $error("five high tms did not reach reset state");

  property p_sel_dr;
    @(posedge tck) disable iff (!tap_rst_n)
    (state_ff == ST_SEL_DR) && tms |=> state_ff == ST_SEL_IR;
  endproperty
  a_sel_dr: assert property (p_sel_dr)
    else $error("bad transition from select-dr");

  property p_ex2_back;
    @(posedge tck) disable iff (!tap_rst_n)
    (state_ff == ST_EX2_DR) && !tms |=> state_ff == ST_SH_DR;
  endproperty
  a_ex2_back: assert property (p_ex2_back)
    else $error("exit2-dr did not return to shift-dr");

  property p_trst_hold;
    @(posedge tck) disable iff (!rst_sync_n)
    !trst_n |-> state_ff == ST_TLR;
  endproperty
  a_trst_hold: assert property (p_trst_hold)
    else $error("test reset low but not in reset state");

  property p_tlr_ir;
    @(posedge tck) disable iff (!tap_rst_n)
    state_ff == ST_TLR |-> ir_ff == IR_IDCODE;
  endproperty
  a_tlr_ir: assert property (p_tlr_ir)
    else $error("reset state without identify instruction");

  property p_upd_ir;
    @(posedge tck) disable iff (!tap_rst_n)
    state_ff == ST_UPD_IR ##1 state_ff != ST_TLR
      |-> ir_ff == $past(ir_sh_ff);
  endproperty
  a_upd_ir: assert property (p_upd_ir)
    else $error("instruction not updated from chain");

  property p_cap_ir;
    @(posedge tck) disable iff (!tap_rst_n)
    state_ff == ST_CAP_IR |=> ir_sh_ff == IR_CAPT_VAL;
  endproperty
  a_cap_ir: assert property (p_cap_ir)
    else $error("instruction chain capture value wrong");

  property p_byp_zero;
    @(posedge tck) disable iff (!tap_rst_n)
    (state_ff == ST_CAP_DR) && (act == IR_BYPASS) |=> dr_sh_ff == 32'h0;
  endproperty
  a_byp_zero: assert property (p_byp_zero)
    else $error("bypass did not capture zero");

  property p_byp_path;
    @(posedge tck) disable iff (!tap_rst_n)
    (state_ff == ST_SH_DR) && (act == IR_BYPASS)
      |=> dr_sh_ff[0] == $past(tdi);
  endproperty
  a_byp_path: assert property (p_byp_path)
    else $error("bypass path lost tdi bit");

  property p_ext_quiet;
    @(posedge tck) disable iff (!tap_rst_n)
    (state_ff == ST_CAP_DR || state_ff == ST_SH_DR ||
     state_ff == ST_UPD_DR) && (act == IR_EXTEST || act == IR_INTEST)
      |=> $stable(dr_sh_ff) && $stable(bdy_upd_ff);
  endproperty
  a_ext_quiet: assert property (p_ext_quiet)
    else $error("extest or intest changed a chain");

  property p_tdo_off;
    @(posedge tck) disable iff (!tap_rst_n)
    (state_ff != ST_SH_IR) && (state_ff != ST_SH_DR) |-> !tdo_oe;
  endproperty
  a_tdo_off: assert property (p_tdo_off)
    else $error("tdo driven outside shift states");

  property p_tdo_ir;
    @(posedge tck) disable iff (!tap_rst_n)
    state_ff == ST_SH_IR |-> tdo_oe && (tdo_o == ir_sh_ff[0]);
  endproperty
  a_tdo_ir: assert property (p_tdo_ir)
    else $error("tdo does not show instruction chain bit");

  property p_core_mux;
    @(posedge tck) disable iff (!tap_rst_n)
    (state_ff == ST_SH_DR) && is_core(act) |-> tdo_oe && core_sel;
  endproperty
  a_core_mux: assert property (p_core_mux)
    else $error("core chain not routed to tdo");

  c_byp_shift: cover property (@(posedge tck) disable iff (!tap_rst_n)
    (state_ff == ST_SH_DR) && (act == IR_BYPASS) [*3]);
  c_id_cap: cover property (@(posedge tck) disable iff (!tap_rst_n)
    (state_ff == ST_CAP_DR) && (act == IR_IDCODE));
  c_ir_upd: cover property (@(posedge tck) disable iff (!tap_rst_n)
    (state_ff == ST_UPD_IR) ##1 (ir_ff == IR_SAMPLE));
  c_upd_sys: cover property (@(posedge clk) disable iff (!rst_sync_n)
    upd_pulse);

endmodule : jtt_tap

// ===== pkg/jtt_pkg.sv
// ==================================================================
// test access port constants
package jtt_pkg;

  // ================================================================
  // instruction register
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_INTEST = 4'h1;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_ABORT = 4'h8;
  localparam logic [3:0] IR_DPACC = 4'ha;
  localparam logic [3:0] IR_APACC = 4'hb;
  localparam logic [3:0] IR_IDCODE = 4'he;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPT_VAL = 4'h1;
  localparam logic [3:0] IR_RST_VAL = IR_IDCODE;

  // ================================================================
  // data chains
  localparam int DR_W = 32;
  localparam int BDY_W = 8;
  localparam logic [5:0] LEN_NONE = 6'h00;
  localparam logic [5:0] LEN_BYPASS = 6'h01;
  localparam logic [5:0] LEN_BDY = 6'h08;
  localparam logic [5:0] LEN_IDCODE = 6'h20;
  localparam logic BYPASS_CAPT_VAL = 1'b0;
  localparam logic [31:0] DR_RST_VAL = 32'h00000000;
  localparam logic [7:0] BDY_RST_VAL = 8'h00;

  // ================================================================
  // misc reset values and counts
  localparam logic ALT_RST_VAL = 1'b1;
  localparam logic SYNC_RST_VAL = 1'b0;
  localparam int TLR_TMS_CYCLES = 5;

  // ================================================================
  // controller states
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jtt_state_type;

endpackage : jtt_pkg

// ===== tb/jtt_host.sv
`timescale 1ns/1ns
// ==================================================================
// test host model, link clock stands still between frames
module jtt_host (
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // lines idle at their pull-up level, test reset held at start
  initial begin
    tck = 1'b0;
    trst_n = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one tck cycle; lines change with the falling edge
  task automatic cyc(input logic m, input logic d, output logic q,
                     output logic e);
    tms <= m;
    tdi <= d;
    #63;
    q = tdo;
    e = tdo_oe;
    tck <= 1'b1;
    #62;
    tck <= 1'b0;
  endtask : cyc

  // five high mode-select cycles, then into run-test-idle
  task automatic to_idle();
    logic q, e;
    repeat (5) cyc(1'b1, 1'b1, q, e);
    cyc(1'b0, 1'b1, q, e);
  endtask : to_idle

  // pulse the test reset pin while the clock is stopped
  task automatic pin_reset();
    trst_n <= 1'b0;
    #300;
    trst_n <= 1'b1;
    #300;
  endtask : pin_reset

  // scan n bits lsb first, from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output int oe_n);
    logic q, e;
    dout = '0;
    oe_n = 0;
    cyc(1'b1, 1'b1, q, e);
    if (ir) cyc(1'b1, 1'b1, q, e);
    cyc(1'b0, 1'b1, q, e);
    cyc(1'b0, 1'b1, q, e);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], q, e);
      dout[i] = q;
      oe_n += (e === 1'b1);
    end
    cyc(1'b1, 1'b1, q, e);
    cyc(1'b0, 1'b1, q, e);
  endtask : scan
endmodule : jtt_host

// ===== tb/tb_top.sv
`timescale 1ns/1ns
// ==================================================================
// bench for the test access port
module tb_top;
  import jtt_pkg::*;

  localparam logic [31:0] ID_V = 32'h0badf00d; // arbitrary value
  logic clk = 1'b0, rstn = 1'b0, core_tdo = 1'b1, alt_bit = 1'b1;
  logic [7:0] bdy_in = 8'h00;
  logic tck, trst_n, tms, tdi, tdo_o, tdo_oe, core_sel, pins_act;
  logic [7:0] bdy_out, upd_word;
  logic bdy_drive, upd_pulse, tdo_pin;
  int num_errors = 0, num_checks = 0, cyc_cnt = 0, upd_cnt = 0;

  // tdo pin has a pull-up when released
  assign tdo_pin = tdo_oe ? tdo_o : 1'b1;
  always #20 clk = ~clk;

  jtt_tap #(.ID_VALUE(ID_V)) DUT (.clk(clk), .rstn(rstn), .tck(tck),
    .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe), .core_tdo(core_tdo), .core_sel(core_sel),
    .alt_function_select_bit(alt_bit), .test_pins_active(pins_act),
    .bdy_in(bdy_in), .bdy_out(bdy_out), .bdy_drive(bdy_drive),
    .upd_word(upd_word), .upd_pulse(upd_pulse));

  jtt_host host (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tdo(tdo_pin), .tdo_oe(tdo_oe));

  // ================================================================
  // cycle ceiling and update pulse counter
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (upd_pulse === 1'b1) upd_cnt <= upd_cnt + 1;
    if (cyc_cnt == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ================================================================
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // load an instruction, checking the captured pattern
  task automatic ld_ir(input logic [3:0] c);
    logic [31:0] d;
    int k;
    host.scan(1'b1, 4, {28'h0, c}, d, k);
    chk(d, {28'h0, IR_CAPT_VAL}, "ir capture");
    chk(32'(k), 32'h4, "ir drive");
  endtask : ld_ir

  // ================================================================
  // scenarios
  task automatic t_id();
    logic [31:0] d;
    int k;
    chk({31'h0, tdo_oe}, 32'h0, "idle oe");
    chk({31'h0, pins_act}, 32'h1, "pins reset");
    host.scan(1'b0, 32, 32'h0, d, k);
    chk(d, ID_V, "default id");
    chk(32'(k), 32'd32, "id drive");
  endtask : t_id

  task automatic t_bypass();
    logic [3:0] cs [3] = '{IR_BYPASS, 4'h5, 4'h3};
    logic [31:0] d;
    int k;
    foreach (cs[i]) begin
      ld_ir(cs[i]);
      host.scan(1'b0, 8, 32'hb6, d, k);
      chk(d, 32'h6c, "bypass delay");
    end
  endtask : t_bypass

  task automatic t_sample();
    logic [31:0] d;
    int k, u;
    @(posedge clk);
    bdy_in <= 8'ha5;
    ld_ir(IR_SAMPLE);
    u = upd_cnt;
    host.scan(1'b0, 8, 32'h3c, d, k);
    chk(d, 32'ha5, "capture");
    chk({24'h0, bdy_out}, 32'h3c, "update");
    repeat (8) @(posedge clk);
    chk(32'(upd_cnt - u), 32'h1, "upd count");
    chk({24'h0, upd_word}, 32'h3c, "upd word");
    repeat (300) @(posedge clk);
    chk({24'h0, bdy_out}, 32'h3c, "stopped hold");
    bdy_in <= 8'h5a;
    host.scan(1'b0, 8, 32'h3c, d, k);
    chk(d, 32'h5a, "ir kept");
  endtask : t_sample

  task automatic t_extest();
    logic [3:0] cs [2] = '{IR_EXTEST, IR_INTEST};
    logic [31:0] d;
    int k;
    foreach (cs[i]) begin
      ld_ir(cs[i]);
      host.scan(1'b0, 8, 32'hff, d, k);
      chk({31'h0, bdy_drive}, 32'(i == 0), "drive");
      chk(32'(k), 32'h0, "no shift");
      chk({24'h0, bdy_out}, 32'h3c, "chain kept");
    end
  endtask : t_extest

  task automatic t_core();
    logic [3:0] cs [3] = '{IR_ABORT, IR_DPACC, IR_APACC};
    logic [31:0] d;
    int k;
    @(posedge clk);
    core_tdo <= 1'b0;
    foreach (cs[i]) begin
      ld_ir(cs[i]);
      chk({31'h0, core_sel}, 32'h1, "core sel");
      host.scan(1'b0, 6, 32'h3f, d, k);
      chk(d, 32'h0, "core data");
      chk(32'(k), 32'h6, "core drive");
    end
    ld_ir(IR_IDCODE);
    chk({31'h0, core_sel}, 32'h0, "own sel");
  endtask : t_core

  // identify scan split by a pause, back through exit2 into shift
  task automatic t_pause();
    logic [31:0] d;
    logic q, e;
    ld_ir(IR_IDCODE);
    host.cyc(1'b1, 1'b1, q, e);
    host.cyc(1'b0, 1'b1, q, e);
    host.cyc(1'b0, 1'b1, q, e);
    for (int i = 0; i < 32; i++) begin
      host.cyc(i == 15 || i == 31, 1'b0, q, e);
      d[i] = q;
      if (i == 15) begin
        host.cyc(1'b0, 1'b1, q, e);
        host.cyc(1'b1, 1'b1, q, e);
        host.cyc(1'b0, 1'b1, q, e);
      end
    end
    host.cyc(1'b1, 1'b1, q, e);
    host.cyc(1'b0, 1'b1, q, e);
    chk(d, ID_V, "paused id");
  endtask : t_pause

  task automatic t_resets();
    logic [31:0] d;
    int k;
    for (int m = 0; m < 3; m++) begin
      ld_ir(IR_BYPASS);
      if (m == 1) host.pin_reset();
      if (m == 2) begin
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
      end
      host.to_idle();
      host.scan(1'b0, 32, 32'h0, d, k);
      chk(d, ID_V, "reset id");
    end
  endtask : t_resets

  task automatic t_alt();
    @(posedge clk);
    alt_bit <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, pins_act}, 32'h0, "gpio use");
    alt_bit <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, pins_act}, 32'h1, "test use");
  endtask : t_alt

  // ================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #7;
    host.pin_reset();
    host.to_idle();
    t_id();
    t_bypass();
    t_sample();
    t_extest();
    t_core();
    t_pause();
    t_resets();
    t_alt();
    finish_test();
  end
endmodule : tb_top
